// ---- bench/buck_voltage_setting_regs_bench.sv ----
// Self-checking bench of the buck voltage registers
`timescale 1ns/1ps
`default_nettype none
module buck_voltage_setting_regs_bench;
  logic core_clk = 1'h0, rst_b = 1'h0, reg_wr_en = 1'h0, reg_rd_en = 1'h0, wr_unlock = 1'h0;
  logic voltage_commit = 1'h0, voltage_commit_alt = 1'h0, monitor_blank_ff;
  logic [7:0] reg_addr = 8'h00, reg_wr_data = 8'h00, reg_rd_data_ff;
  logic [1:0] light_load = 2'h0, pulse_skip_active_ff;
  logic [5:0] buck1_voltage_code_ff, buck2_voltage_code_ff;
  logic [10:0] buck1_target_mv_ff, buck2_target_mv_ff;
  int fail_count = 0, checks_done = 0;
  always #2 core_clk = ~core_clk;
  // Short blanking keeps the run brief
  buck_voltage_setting_regs #(.BLANK_CYCLES(21'h14)) dut_u (.*);
  task automatic cmp(input logic [10:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d, input logic u);
    @(negedge core_clk);
    {reg_addr, reg_wr_data, wr_unlock, reg_wr_en} = {a, d, u, 1'h1};
    @(negedge core_clk);
    reg_wr_en = 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(negedge core_clk);
    {reg_addr, reg_rd_en} = {a, 1'h1};
    @(negedge core_clk);
    reg_rd_en = 1'h0;
    cmp(reg_rd_data_ff, exp);
  endtask
  task automatic go(input logic alt);
    @(negedge core_clk);
    {voltage_commit_alt, voltage_commit} = {alt, !alt};
    @(negedge core_clk);
    {voltage_commit_alt, voltage_commit} = 2'h0;
  endtask
  task automatic t_lock;
    rd(8'h17, 8'h99);
    wr(8'h16, 8'h00, 1'h0);
    rd(8'h16, 8'h99);
    cmp(monitor_blank_ff, 1'h0);
  endtask
  task automatic t_commit;
    wr(8'h16, 8'h7F, 1'h1);
    cmp(monitor_blank_ff, 1'h1);
    rd(8'h16, 8'h3F);
    cmp(buck1_target_mv_ff, 11'h44C);
    go(1'h1);
    cmp(buck1_voltage_code_ff, 6'h3F);
    cmp(buck1_target_mv_ff, 11'h68B);
    wr(8'h17, 8'hB2, 1'h1);
    rd(8'h17, 8'hB2);
    cmp(buck2_voltage_code_ff, 6'h19);
    go(1'h0);
    cmp(buck2_voltage_code_ff, 6'h32);
    cmp(buck2_target_mv_ff, 11'h546);
    repeat (25) @(negedge core_clk);
    cmp(monitor_blank_ff, 1'h0);
  endtask
  task automatic t_skip;
    light_load = 2'h3;
    repeat (8) @(negedge core_clk);
    cmp(pulse_skip_active_ff, 2'h2);
    light_load = 2'h0;
    repeat (8) @(negedge core_clk);
    cmp(pulse_skip_active_ff, 2'h0);
  endtask
  task automatic end_sim;
    if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge core_clk);
    rst_b = 1'h1;
    t_lock;
    t_commit;
    t_skip;
    end_sim;
  end
  initial begin
    #4000;
    fail_count++;
    end_sim;
  end
endmodule
`default_nettype wire

// ---- bench/buck_voltage_setting_regs_chk.sv ----
// Port checker of the buck voltage registers
`timescale 1ns/1ps
`default_nettype none
module buck_voltage_setting_regs_chk (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic wr_unlock,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rd_data_ff,
  input wire logic voltage_commit,
  input wire logic voltage_commit_alt,
  input wire logic [1:0] light_load,
  input wire logic [5:0] buck1_voltage_code_ff,
  input wire logic [5:0] buck2_voltage_code_ff,
  input wire logic [10:0] buck1_target_mv_ff,
  input wire logic [10:0] buck2_target_mv_ff,
  input wire logic [1:0] pulse_skip_active_ff,
  input wire logic monitor_blank_ff
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire logic go = voltage_commit | voltage_commit_alt;
  wire logic acc = reg_wr_en & wr_unlock & (reg_addr[7:1] == 7'h0B);
  function automatic int mv(input logic [5:0] c);
    return (c <= 6'h32) ? 850 + 10 * c : 100 + 25 * c;
  endfunction
  a_rsvd_reads_zero: assert property (reg_rd_en |=> !reg_rd_data_ff[6])
    else $error("reserved bit read high");
  a_code1_held: assert property (!go |=> $stable(buck1_voltage_code_ff))
    else $error("code one moved without commit");
  a_code2_held: assert property (!go |=> $stable(buck2_voltage_code_ff))
    else $error("code two moved without commit");
  a_blank_on_write: assert property (acc |=> monitor_blank_ff)
    else $error("no blanking after write");
  a_blank_locked: assert property (!monitor_blank_ff && !acc |=> !monitor_blank_ff)
    else $error("blanking without accepted write");
  a_skip_needs_load: assert property ((light_load == 2'h0) [*8] |-> !pulse_skip_active_ff)
    else $error("pulse skip at heavy load");
  a_mv_one: assert property (buck1_target_mv_ff == mv(buck1_voltage_code_ff))
    else $error("voltage one mapping");
  a_mv_two: assert property (buck2_target_mv_ff == mv(buck2_voltage_code_ff))
    else $error("voltage two mapping");
endmodule
bind buck_voltage_setting_regs buck_voltage_setting_regs_chk chk_u (.*);
`default_nettype wire

// ---- hdl/buck_voltage_setting_defines.vh ----
// Offsets, field layout, reset values and timing counts of the buck voltage registers
`ifndef BUCK_VOLTAGE_SETTING_DEFINES_VH
`define BUCK_VOLTAGE_SETTING_DEFINES_VH
// ==========================================================
// Register offsets
`define BUCK1_VOLTAGE_CONFIG_ADDR 8'h16
`define BUCK2_VOLTAGE_CONFIG_ADDR 8'h17
`define COMMIT_REG_ADDR 8'h1A
// ==========================================================
// Field layout
`define PULSE_SKIP_BIT 7
`define RESERVED_BIT 6
`define CODE_MSB 5
`define CODE_LSB 0
// ==========================================================
// Reset values
`define BUCK_CONFIG_RESET 8'h99
`define PULSE_SKIP_RESET 1'h1
`define CODE_RESET 6'h19
`define MV_RESET 11'h44C
// ==========================================================
// Voltage code mapping, millivolts
`define CODE_BREAK 6'h32
`define MV_BASE 11'h352
`define MV_FINE_STEP 11'h00A
`define MV_BREAK 11'h546
`define MV_COARSE_STEP 11'h019
// ==========================================================
// Timing
`define CLK_FREQ_MHZ 250
`define BLANK_TIME_US 5000
`define BLANK_CYCLES 21'h1312D0
`define BLANK_CNT_W 21
`endif

// ---- hdl/buck_voltage_setting_regs.v ----
// Voltage and light-load configuration registers of the first two step-down converters
// ==========================================================
`timescale 1ns/1ps
`default_nettype none
`include "buck_voltage_setting_defines.vh"
module buck_voltage_setting_regs #(
  parameter [`BLANK_CNT_W-1:0] BLANK_CYCLES = `BLANK_CYCLES
) (
  input wire core_clk,
  input wire rst_b,
  input wire [7:0] reg_addr,
  input wire reg_wr_en,
  input wire [7:0] reg_wr_data,
  input wire reg_rd_en,
  output reg [7:0] reg_rd_data_ff,
  input wire wr_unlock,
  input wire voltage_commit,
  input wire voltage_commit_alt,
  input wire [1:0] light_load,
  output reg [5:0] buck1_voltage_code_ff,
  output reg [5:0] buck2_voltage_code_ff,
  output reg [10:0] buck1_target_mv_ff,
  output reg [10:0] buck2_target_mv_ff,
  output reg [1:0] pulse_skip_active_ff,
  output reg monitor_blank_ff
);
  // ==========================================================
  // Address decode
  function reg_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      reg_hit = (addr == target);
    end
  endfunction

  // ==========================================================
  // Read image; the reserved bit is tied low, never stored
  function [7:0] pack_reg;
    input skip;
    input [5:0] code;
    begin
      pack_reg = {skip, 1'b0, code};
    end
  endfunction

  // ==========================================================
  // Code to millivolt mapping, fine steps up to the break code
  function [10:0] code_to_mv;
    input [5:0] code;
    begin
      if (code <= `CODE_BREAK) begin
        code_to_mv = `MV_BASE + {5'h00, code} * `MV_FINE_STEP;
      end else begin
        code_to_mv = `MV_BREAK + {5'h00, code - `CODE_BREAK} * `MV_COARSE_STEP;
      end
    end
  endfunction

  // ==========================================================
  // Internal state
  reg pulse_skip1_ff;
  reg pulse_skip2_ff;
  reg [5:0] buck1_prog_ff;
  reg [5:0] buck2_prog_ff;
  reg [`BLANK_CNT_W-1:0] blank_cnt_ff;
  reg [1:0] ll_s1_ff;
  reg [1:0] ll_s2_ff;
  reg [1:0] ll_s3_ff;
  reg [1:0] ll_ff;
  reg [1:0] nxt_ll;
  reg [7:0] nxt_rd_data;
  wire [1:0] pulse_skip_enable;
  wire hit1;
  wire hit2;
  wire wr_ok1;
  wire wr_ok2;
  wire wr_ok;
  wire commit;

  // ==========================================================
  // Write qualification
  assign hit1 = reg_hit(reg_addr, `BUCK1_VOLTAGE_CONFIG_ADDR);
  assign hit2 = reg_hit(reg_addr, `BUCK2_VOLTAGE_CONFIG_ADDR);
  // Locked writes vanish silently
  assign wr_ok1 = reg_wr_en & wr_unlock & hit1;
  assign wr_ok2 = reg_wr_en & wr_unlock & hit2;
  assign wr_ok = wr_ok1 | wr_ok2;
  assign commit = voltage_commit | voltage_commit_alt;
  assign pulse_skip_enable = {pulse_skip2_ff, pulse_skip1_ff};

  // ==========================================================
  // First converter programmed fields
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pulse_skip1_ff <= `PULSE_SKIP_RESET;
      buck1_prog_ff <= `CODE_RESET;
    end else if (wr_ok1) begin
      pulse_skip1_ff <= reg_wr_data[`PULSE_SKIP_BIT];
      buck1_prog_ff <= reg_wr_data[`CODE_MSB:`CODE_LSB];
    end
  end

  // ==========================================================
  // Second converter programmed fields
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pulse_skip2_ff <= `PULSE_SKIP_RESET;
      buck2_prog_ff <= `CODE_RESET;
    end else if (wr_ok2) begin
      pulse_skip2_ff <= reg_wr_data[`PULSE_SKIP_BIT];
      buck2_prog_ff <= reg_wr_data[`CODE_MSB:`CODE_LSB];
    end
  end

  // ==========================================================
  // Read back; unmapped addresses read zero
  always @* begin
    nxt_rd_data = 8'h00;
    if (hit1) begin
      nxt_rd_data = pack_reg(pulse_skip1_ff, buck1_prog_ff);
    end else if (hit2) begin
      nxt_rd_data = pack_reg(pulse_skip2_ff, buck2_prog_ff);
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rd_data_ff <= 8'h00;
    end else if (reg_rd_en) begin
      reg_rd_data_ff <= nxt_rd_data;
    end
  end

  // ==========================================================
  // First converter applied code; a commit in the write cycle takes the old code
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      buck1_voltage_code_ff <= `CODE_RESET;
      buck1_target_mv_ff <= `MV_RESET;
    end else if (commit) begin
      buck1_voltage_code_ff <= buck1_prog_ff;
      buck1_target_mv_ff <= code_to_mv(buck1_prog_ff);
    end
  end

  // ==========================================================
  // Second converter applied code
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      buck2_voltage_code_ff <= `CODE_RESET;
      buck2_target_mv_ff <= `MV_RESET;
    end else if (commit) begin
      buck2_voltage_code_ff <= buck2_prog_ff;
      buck2_target_mv_ff <= code_to_mv(buck2_prog_ff);
    end
  end

  // ==========================================================
  // Monitor blanking, restarted by every accepted write
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      blank_cnt_ff <= {`BLANK_CNT_W{1'b0}};
      monitor_blank_ff <= 1'b0;
    end else if (wr_ok) begin
      blank_cnt_ff <= BLANK_CYCLES - 1'b1;
      monitor_blank_ff <= 1'b1;
    end else if (blank_cnt_ff != {`BLANK_CNT_W{1'b0}}) begin
      blank_cnt_ff <= blank_cnt_ff - 1'b1;
    end else begin
      monitor_blank_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Load condition from the analog side, three-stage synchroniser
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ll_s1_ff <= 2'h0;
      ll_s2_ff <= 2'h0;
      ll_s3_ff <= 2'h0;
    end else begin
      ll_s1_ff <= light_load;
      ll_s2_ff <= ll_s1_ff;
      ll_s3_ff <= ll_s2_ff;
    end
  end

  // ==========================================================
  // Bitwise agree filter rejects one-cycle glitches
  always @* begin
    nxt_ll = (ll_s2_ff & ll_s3_ff) | (ll_ff & (ll_s2_ff | ll_s3_ff));
  end

  // ==========================================================
  // Pulse-skip only when enabled and the load is light
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ll_ff <= 2'h0;
      pulse_skip_active_ff <= 2'h0;
    end else begin
      ll_ff <= nxt_ll;
      pulse_skip_active_ff <= pulse_skip_enable & ll_ff;
    end
  end
endmodule
`default_nettype wire
